// file: core/scel_pkg.sv
// Package for the serial configuration EEPROM loader: byte map, register map and states.
// Assumes a two-wire EEPROM read sequentially from byte address zero.
package scel_pkg;

  localparam int unsigned LOAD_BYTES       = 23;
  localparam logic [4:0]  LOAD_COUNT       = 5'h17;
  localparam logic [7:0]  WORD_ADDR_START  = 8'h00;
  localparam logic        RW_WRITE         = 1'b0;
  localparam logic        RW_READ          = 1'b1;
  localparam logic [7:0]  BYTE_RESET       = 8'h00;

  // Byte positions inside the EEPROM image.
  localparam logic [4:0]  IDX_LAT_GNT      = 5'h00;
  localparam logic [4:0]  IDX_VENDOR_LO    = 5'h01;
  localparam logic [4:0]  IDX_VENDOR_HI    = 5'h02;
  localparam logic [4:0]  IDX_SUBSYS_LO    = 5'h03;
  localparam logic [4:0]  IDX_SUBSYS_HI    = 5'h04;
  localparam logic [4:0]  IDX_ENHANCE      = 5'h05;
  localparam logic [4:0]  IDX_GUID_ROM     = 5'h06;
  localparam logic [4:0]  IDX_GUID_HI0     = 5'h07;
  localparam logic [4:0]  IDX_GUID_LO0     = 5'h0B;
  localparam logic [4:0]  IDX_LINK_ENH     = 5'h10;
  localparam logic [4:0]  IDX_MISC_LO      = 5'h11;
  localparam logic [4:0]  IDX_MISC_HI      = 5'h12;
  localparam logic [4:0]  IDX_CIS          = 5'h14;
  localparam logic [4:0]  IDX_PHY_CTRL     = 5'h16;
  localparam int unsigned CABLE_EN_BIT     = 7;

  // Register offsets, byte addresses of 32-bit words.
  localparam logic [7:0]  REG_STATUS       = 8'h00;
  localparam logic [7:0]  REG_CONTROL      = 8'h04;
  localparam logic [7:0]  REG_IDS          = 8'h08;
  localparam logic [7:0]  REG_GUID_HI      = 8'h0C;
  localparam logic [7:0]  REG_GUID_LO      = 8'h10;
  localparam logic [7:0]  REG_CFG_A        = 8'h14;
  localparam logic [7:0]  REG_CFG_B        = 8'h18;

  // Field positions.
  localparam int unsigned ST_BUSY_BIT      = 0;
  localparam int unsigned ST_DONE_BIT      = 1;
  localparam int unsigned ST_NOACK_BIT     = 2;
  localparam int unsigned ST_CABLE_BIT     = 3;
  localparam int unsigned ST_COUNT_LSB     = 8;
  localparam int unsigned CTRL_RELOAD_BIT  = 0;

  typedef enum logic [1:0] {
    LD_LOAD    = 2'b00,
    LD_RELEASE = 2'b01,
    LD_DONE    = 2'b11
  } scel_load_state_e;

  typedef enum logic [3:0] {
    LK_IDLE   = 4'b0000,
    LK_START  = 4'b0001,
    LK_SEND   = 4'b0011,
    LK_SACK   = 4'b0010,
    LK_RECV   = 4'b0110,
    LK_MACK   = 4'b0111,
    LK_STOP   = 4'b0101,
    LK_FINISH = 4'b0100
  } scel_link_state_e;

endpackage

// file: core/scel_link_if.sv
// Interface between the loader in the device clock domain and the two-wire engine.
// Every signal crosses domains; the receiving side synchronises all but byteData, which is held stable behind byteToggle.
interface scel_link_if;
  logic       loadRequest;
  logic [7:0] byteData;
  logic       byteToggle;
  logic       engineDone;
  logic       noAck;

  modport loader (output loadRequest, input byteData, input byteToggle,
                  input engineDone, input noAck);
  modport engine (input loadRequest, output byteData, output byteToggle,
                  output engineDone, output noAck);
endinterface

// file: core/scel_sync.sv
// Two flip-flop synchroniser for a group of independent level signals.
// Assumes each bit may change at any time relative to clock.
module scel_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage_reg <= '0;
      q         <= '0;
    end else if (enable) begin
      stage_reg <= d;
      q         <= stage_reg;
    end
  end
endmodule

// file: core/scel_twi_engine.sv
// Two-wire master engine that reads the EEPROM image sequentially from address zero.
// Runs on the free-running link clock; one bit takes four link clock cycles.
module scel_twi_engine #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic         linkClock,
  input  wire logic         rst,
  input  wire logic         clockEnable,
  input  wire logic         sdaIn,
  output logic              sdaLow,
  output logic              sclLow,
  scel_link_if.engine       link
);
  scel_pkg::scel_link_state_e state_reg, state_next;
  logic [1:0] quarter_reg, quarter_next;
  logic [2:0] bitCount_reg, bitCount_next;
  logic [1:0] step_reg, step_next;
  logic [7:0] shift_reg, shift_next;
  logic [4:0] byteCount_reg, byteCount_next;
  logic       sample_reg, sample_next;
  logic [7:0] byteData_reg, byteData_next;
  logic       toggle_reg, toggle_next;
  logic       done_reg, done_next;
  logic       noAck_reg, noAck_next;
  logic       sclLow_next, sdaLow_next;
  logic [2:0] syncIn, syncOut;
  logic       reqS, enS, sdaS, lastQ;

  assign syncIn = {link.loadRequest, clockEnable, sdaIn};
  assign {reqS, enS, sdaS} = syncOut;

  scel_sync #(.WIDTH(3)) inSync (
    .clock  (linkClock),
    .rst    (rst),
    .enable (1'b1),
    .d      (syncIn),
    .q      (syncOut)
  );

  // Pin levels for one quarter of a bit; data changes only while the clock line is low, except for the start and stop edges.
  function automatic logic [1:0] pinDrive(input scel_pkg::scel_link_state_e st,
                                          input logic [1:0] q, input logic dataBit,
                                          input logic ackLow);
    logic lowPhase;
    lowPhase = (q == 2'd0) || (q == 2'd3);
    case (st)
      scel_pkg::LK_START: pinDrive = {lowPhase, q[1]};
      scel_pkg::LK_SEND:  pinDrive = {lowPhase, ~dataBit};
      scel_pkg::LK_SACK:  pinDrive = {lowPhase, 1'b0};
      scel_pkg::LK_RECV:  pinDrive = {lowPhase, 1'b0};
      scel_pkg::LK_MACK:  pinDrive = {lowPhase, ackLow};
      scel_pkg::LK_STOP:  pinDrive = {q == 2'd0, ~q[1]};
      default:            pinDrive = 2'b00;
    endcase
  endfunction

  always_comb begin
    state_next     = state_reg;
    quarter_next   = quarter_reg;
    bitCount_next  = bitCount_reg;
    step_next      = step_reg;
    shift_next     = shift_reg;
    byteCount_next = byteCount_reg;
    sample_next    = sample_reg;
    byteData_next  = byteData_reg;
    toggle_next    = toggle_reg;
    done_next      = done_reg;
    noAck_next     = noAck_reg;
    lastQ          = quarter_reg == 2'd3;
    if (state_reg != scel_pkg::LK_IDLE && state_reg != scel_pkg::LK_FINISH) begin
      quarter_next = quarter_reg + 2'd1;
    end
    case (state_reg)
      scel_pkg::LK_IDLE: begin
        if (reqS) begin
          state_next     = scel_pkg::LK_START;
          quarter_next   = 2'd0;
          step_next      = 2'd0;
          byteCount_next = 5'h00;
          noAck_next     = 1'b0;
          shift_next     = {DEV_ADDR, scel_pkg::RW_WRITE};
        end
      end
      scel_pkg::LK_START: begin
        if (lastQ) begin
          state_next    = scel_pkg::LK_SEND;
          bitCount_next = 3'd7;
        end
      end
      scel_pkg::LK_SEND: begin
        if (lastQ) begin
          shift_next = {shift_reg[6:0], 1'b0};
          if (bitCount_reg == 3'd0) begin
            state_next = scel_pkg::LK_SACK;
          end else begin
            bitCount_next = bitCount_reg - 3'd1;
          end
        end
      end
      scel_pkg::LK_SACK: begin
        if (quarter_reg == 2'd2) begin
          sample_next = sdaS;
        end
        if (lastQ) begin
          bitCount_next = 3'd7;
          if (sample_reg) begin
            noAck_next = 1'b1;
            state_next = scel_pkg::LK_STOP;
          end else if (step_reg == 2'd0) begin
            step_next  = 2'd1;
            shift_next = scel_pkg::WORD_ADDR_START;
            state_next = scel_pkg::LK_SEND;
          end else if (step_reg == 2'd1) begin
            step_next  = 2'd2;
            shift_next = {DEV_ADDR, scel_pkg::RW_READ};
            state_next = scel_pkg::LK_START;
          end else begin
            state_next = scel_pkg::LK_RECV;
          end
        end
      end
      scel_pkg::LK_RECV: begin
        if (quarter_reg == 2'd2) begin
          shift_next = {shift_reg[6:0], sdaS};
        end
        if (lastQ) begin
          if (bitCount_reg == 3'd0) begin
            state_next     = scel_pkg::LK_MACK;
            byteData_next  = shift_reg;
            toggle_next    = ~toggle_reg;
            byteCount_next = byteCount_reg + 5'h01;
          end else begin
            bitCount_next = bitCount_reg - 3'd1;
          end
        end
      end
      scel_pkg::LK_MACK: begin
        if (lastQ) begin
          bitCount_next = 3'd7;
          if (byteCount_reg == scel_pkg::LOAD_COUNT) begin
            state_next = scel_pkg::LK_STOP;
          end else begin
            state_next = scel_pkg::LK_RECV;
          end
        end
      end
      scel_pkg::LK_STOP: begin
        if (lastQ) begin
          state_next = scel_pkg::LK_FINISH;
          done_next  = 1'b1;
        end
      end
      default: begin
        if (!reqS) begin
          state_next = scel_pkg::LK_IDLE;
          done_next  = 1'b0;
        end
      end
    endcase
    {sclLow_next, sdaLow_next} = pinDrive(state_next, quarter_next, shift_next[7],
                                          byteCount_next != scel_pkg::LOAD_COUNT);
  end

  always_ff @(posedge linkClock or posedge rst) begin
    if (rst) begin
      state_reg     <= scel_pkg::LK_IDLE;
      quarter_reg   <= 2'd0;
      bitCount_reg  <= 3'd0;
      step_reg      <= 2'd0;
      shift_reg     <= 8'h00;
      byteCount_reg <= 5'h00;
      sample_reg    <= 1'b0;
      byteData_reg  <= 8'h00;
      toggle_reg    <= 1'b0;
      done_reg      <= 1'b0;
      noAck_reg     <= 1'b0;
      sclLow        <= 1'b0;
      sdaLow        <= 1'b0;
    end else if (enS) begin
      state_reg     <= state_next;
      quarter_reg   <= quarter_next;
      bitCount_reg  <= bitCount_next;
      step_reg      <= step_next;
      shift_reg     <= shift_next;
      byteCount_reg <= byteCount_next;
      sample_reg    <= sample_next;
      byteData_reg  <= byteData_next;
      toggle_reg    <= toggle_next;
      done_reg      <= done_next;
      noAck_reg     <= noAck_next;
      sclLow        <= sclLow_next;
      sdaLow        <= sdaLow_next;
    end
  end

  assign link.byteData   = byteData_reg;
  assign link.byteToggle = toggle_reg;
  assign link.engineDone = done_reg;
  assign link.noAck      = noAck_reg;
endmodule

// file: core/scel_loader.sv
// Top of the serial configuration EEPROM loader: load sequencing, image storage,
// slave-retry control and the register port.
// Assumes a free-running link clock and an open-drain two-wire bus with pull-ups.

module scel_loader #(
  parameter logic [6:0] EEPROM_DEV_ADDR = 7'h50
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clockEnable,
  input  wire logic        linkClock,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWriteData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regReadData,
  output logic             pciRetry,
  output logic             loadDone,
  input  wire logic        cableInactiveStatus,
  output logic             cableInactiveOutput
);
  scel_link_if link ();

  scel_pkg::scel_load_state_e state_reg, state_next;
  logic [7:0]  eepromByte_reg [0:scel_pkg::LOAD_BYTES-1];
  logic [7:0]  eepromByte_next [0:scel_pkg::LOAD_BYTES-1];
  logic [4:0]  byteIndex_reg, byteIndex_next;
  logic        toggleSeen_reg, toggleSeen_next;
  logic        noAck_reg, noAck_next;
  logic        retry_next, done_next, cable_next;
  logic [31:0] readData_next;
  logic [2:0]  syncIn, syncOut;
  logic        toggleS, doneS, noAckS, byteArrived, reloadWrite;
  logic [15:0] vendorId, subsystemId;
  logic [31:0] guidHigh, guidLow;

  assign syncIn = {link.byteToggle, link.engineDone, link.noAck};
  assign {toggleS, doneS, noAckS} = syncOut;

  scel_sync #(.WIDTH(3)) linkSync (
    .clock  (clock),
    .rst    (rst),
    .enable (clockEnable),
    .d      (syncIn),
    .q      (syncOut)
  );

  scel_twi_engine #(.DEV_ADDR(EEPROM_DEV_ADDR)) engine (
    .linkClock   (linkClock),
    .rst         (rst),
    .clockEnable (clockEnable),
    .sdaIn       (sdaIn),
    .sdaLow      (sdaOe),
    .sclLow      (sclOe),
    .link        (link)
  );

  // Open-drain pins only ever pull low.
  assign sdaOut = 1'b0;
  assign sclOut = 1'b0;

  // The request level starts the engine right after reset and holds until it finishes.
  assign link.loadRequest = (state_reg == scel_pkg::LD_LOAD);

  // Byte data is stable for a whole bit time after its toggle, well past the sync delay.
  assign byteArrived = toggleS != toggleSeen_reg;
  assign reloadWrite = regWrite && (regAddr == scel_pkg::REG_CONTROL) &&
                       regWriteData[scel_pkg::CTRL_RELOAD_BIT];

  assign vendorId    = {eepromByte_reg[scel_pkg::IDX_VENDOR_HI],
                        eepromByte_reg[scel_pkg::IDX_VENDOR_LO]};
  assign subsystemId = {eepromByte_reg[scel_pkg::IDX_SUBSYS_HI],
                        eepromByte_reg[scel_pkg::IDX_SUBSYS_LO]};
  assign guidHigh    = {eepromByte_reg[scel_pkg::IDX_GUID_HI0 + 5'h03],
                        eepromByte_reg[scel_pkg::IDX_GUID_HI0 + 5'h02],
                        eepromByte_reg[scel_pkg::IDX_GUID_HI0 + 5'h01],
                        eepromByte_reg[scel_pkg::IDX_GUID_HI0]};
  assign guidLow     = {eepromByte_reg[scel_pkg::IDX_GUID_LO0 + 5'h03],
                        eepromByte_reg[scel_pkg::IDX_GUID_LO0 + 5'h02],
                        eepromByte_reg[scel_pkg::IDX_GUID_LO0 + 5'h01],
                        eepromByte_reg[scel_pkg::IDX_GUID_LO0]};

  always_comb begin
    state_next      = state_reg;
    byteIndex_next  = byteIndex_reg;
    toggleSeen_next = toggleS;
    noAck_next      = noAck_reg;
    for (int i = 0; i < scel_pkg::LOAD_BYTES; i++) begin
      eepromByte_next[i] = eepromByte_reg[i];
    end
    case (state_reg)
      scel_pkg::LD_LOAD: begin
        if (byteArrived && byteIndex_reg < scel_pkg::LOAD_COUNT) begin
          eepromByte_next[byteIndex_reg] = link.byteData;
          byteIndex_next = byteIndex_reg + 5'h01;
        end
        if (doneS) begin
          noAck_next = noAckS;
          state_next = scel_pkg::LD_RELEASE;
        end
      end
      scel_pkg::LD_RELEASE: begin
        if (!doneS) begin
          state_next = scel_pkg::LD_DONE;
        end
      end
      default: begin
        if (reloadWrite) begin
          state_next     = scel_pkg::LD_LOAD;
          byteIndex_next = 5'h00;
        end
      end
    endcase
    retry_next = state_next != scel_pkg::LD_DONE;
    done_next  = state_next == scel_pkg::LD_DONE;
    cable_next = eepromByte_reg[scel_pkg::IDX_PHY_CTRL][scel_pkg::CABLE_EN_BIT] &&
                 cableInactiveStatus;
  end

  always_comb begin
    readData_next = 32'h0000_0000;
    if (regRead) begin
      if (regAddr == scel_pkg::REG_STATUS) begin
        readData_next[scel_pkg::ST_BUSY_BIT]  = pciRetry;
        readData_next[scel_pkg::ST_DONE_BIT]  = loadDone;
        readData_next[scel_pkg::ST_NOACK_BIT] = noAck_reg;
        readData_next[scel_pkg::ST_CABLE_BIT] =
          eepromByte_reg[scel_pkg::IDX_PHY_CTRL][scel_pkg::CABLE_EN_BIT];
        readData_next[scel_pkg::ST_COUNT_LSB +: 5] = byteIndex_reg;
      end else if (regAddr == scel_pkg::REG_IDS) begin
        readData_next = {subsystemId, vendorId};
      end else if (regAddr == scel_pkg::REG_GUID_HI) begin
        readData_next = guidHigh;
      end else if (regAddr == scel_pkg::REG_GUID_LO) begin
        readData_next = guidLow;
      end else if (regAddr == scel_pkg::REG_CFG_A) begin
        readData_next = {eepromByte_reg[scel_pkg::IDX_PHY_CTRL],
                         eepromByte_reg[scel_pkg::IDX_CIS],
                         eepromByte_reg[scel_pkg::IDX_GUID_ROM],
                         eepromByte_reg[scel_pkg::IDX_ENHANCE]};
      end else if (regAddr == scel_pkg::REG_CFG_B) begin
        readData_next = {eepromByte_reg[scel_pkg::IDX_MISC_HI],
                         eepromByte_reg[scel_pkg::IDX_MISC_LO],
                         eepromByte_reg[scel_pkg::IDX_LINK_ENH],
                         eepromByte_reg[scel_pkg::IDX_LAT_GNT]};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg           <= scel_pkg::LD_LOAD;
      byteIndex_reg       <= 5'h00;
      toggleSeen_reg      <= 1'b0;
      noAck_reg           <= 1'b0;
      pciRetry            <= 1'b1;
      loadDone            <= 1'b0;
      cableInactiveOutput <= 1'b0;
      regReadData         <= 32'h0000_0000;
      for (int i = 0; i < scel_pkg::LOAD_BYTES; i++) begin
        eepromByte_reg[i] <= scel_pkg::BYTE_RESET;
      end
    end else if (clockEnable) begin
      state_reg           <= state_next;
      byteIndex_reg       <= byteIndex_next;
      toggleSeen_reg      <= toggleSeen_next;
      noAck_reg           <= noAck_next;
      pciRetry            <= retry_next;
      loadDone            <= done_next;
      cableInactiveOutput <= cable_next;
      regReadData         <= readData_next;
      for (int i = 0; i < scel_pkg::LOAD_BYTES; i++) begin
        eepromByte_reg[i] <= eepromByte_next[i];
      end
    end
  end
endmodule

// file: verification/scel_loader_chk.sv
// Concurrent checks on the loader's top-level ports.
// Assumes it is bound into scel_loader and sees only that module's ports.
module scel_loader_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        linkClock,
  input wire logic        sdaOe,
  input wire logic        sclOe,
  input wire logic        sdaOut,
  input wire logic        sclOut,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regReadData,
  input wire logic        pciRetry,
  input wire logic        loadDone,
  input wire logic        cableInactiveStatus,
  input wire logic        cableInactiveOutput
);
  timeunit 1ns;
  timeprecision 1ps;
  sequence reloadReq;
    regWrite && regAddr == scel_pkg::REG_CONTROL && regWriteData[scel_pkg::CTRL_RELOAD_BIT] &&
    loadDone;
  endsequence
  sequence statusRead;
    regRead && regAddr == scel_pkg::REG_STATUS;
  endsequence

  busy_done_excl_a: assert property (@(posedge clock) disable iff (rst)
    !(pciRetry && loadDone)) else $error("busy and done high together");
  retry_at_start_a: assert property (@(posedge clock) disable iff (rst)
    $fell(rst) |-> pciRetry && !loadDone) else $error("no retry after reset");
  link_quiet_a: assert property (@(posedge clock) disable iff (rst)
    $fell(rst) |-> !sdaOe && !sclOe) else $error("bus driven at reset release");
  read_idle_a: assert property (@(posedge clock) disable iff (rst)
    !regRead |=> regReadData == 32'h0) else $error("read data without strobe");
  status_read_a: assert property (@(posedge clock) disable iff (rst)
    statusRead |=> regReadData[1:0] == {$past(loadDone), $past(pciRetry)})
    else $error("status busy or done wrong");
  cable_gate_a: assert property (@(posedge clock) disable iff (rst)
    cableInactiveOutput |-> $past(cableInactiveStatus)) else $error("cable output ungated");
  reload_retry_a: assert property (@(posedge clock) disable iff (rst)
    reloadReq |-> ##[1:4] pciRetry) else $error("reload did not start retry");
  done_hold_a: assert property (@(posedge clock) disable iff (rst)
    loadDone && !regWrite |=> loadDone) else $error("done dropped");
  retry_end_a: assert property (@(posedge clock) disable iff (rst)
    $fell(pciRetry) |-> ##[0:4] loadDone) else $error("retry ended without done");
  scl_high_a: assert property (@(posedge linkClock) disable iff (rst)
    $fell(sclOe) |=> !sclOe) else $error("clock high phase too short");
  open_drain_a: assert property (@(posedge clock) disable iff (rst)
    !sdaOut && !sclOut) else $error("open-drain pin driven high");
endmodule

bind scel_loader scel_loader_chk chk (
  .clock(clock), .rst(rst), .linkClock(linkClock), .sdaOe(sdaOe), .sclOe(sclOe),
  .sdaOut(sdaOut), .sclOut(sclOut),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .regRead(regRead), .regReadData(regReadData), .pciRetry(pciRetry),
  .loadDone(loadDone), .cableInactiveStatus(cableInactiveStatus),
  .cableInactiveOutput(cableInactiveOutput)
);

// file: verification/scel_eeprom_model.sv
// Behavioural two-wire EEPROM answering sequential reads.
// Assumes open-drain wires with pull-ups; it only ever pulls data low.
module scel_eeprom_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic present,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:31];
  logic [7:0] shiftIn;
  logic [7:0] outByte;
  logic [4:0] ptr;
  logic [3:0] bitCnt;
  logic [1:0] byteNum;
  logic       active;
  logic       readMode;
  logic       sendNext;
  logic       masterAck;
  initial begin
    sdaLow = 1'b0;
    active = 1'b0;
    ptr = 5'h00;
  end
  // A data edge while the clock wire is high frames a transfer.
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      bitCnt = 4'h0;
      byteNum = 2'h0;
      readMode = 1'b0;
      sendNext = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (active) begin
      if (bitCnt < 4'h8) shiftIn = {shiftIn[6:0], sda};
      else masterAck = !sda;
      bitCnt = bitCnt + 4'h1;
    end
  end
  // Data changes only while the clock wire is low.
  always @(negedge scl) begin
    if (active) begin
      sdaLow = 1'b0;
      if (bitCnt == 4'h8 && !readMode) begin
        sdaLow = (byteNum != 2'h0) || (present && shiftIn[7:1] == DEV_ADDR);
        if (byteNum == 2'h1) ptr = shiftIn[4:0];
        sendNext = byteNum == 2'h0 && shiftIn[0] && sdaLow;
        byteNum = byteNum + 2'h1;
      end else if (bitCnt == 4'h9) begin
        bitCnt = 4'h0;
        if (sendNext || (readMode && masterAck)) begin
          readMode = 1'b1;
          sendNext = 1'b0;
          outByte = mem[ptr];
          ptr = ptr + 5'h01;
          sdaLow = !outByte[7];
        end
      end else if (readMode && bitCnt < 4'h8) begin
        sdaLow = !outByte[3'(7 - bitCnt)];
      end
    end
  end
endmodule

// file: verification/scel_loader_test.sv
// Self-checking bench for the EEPROM loader: register port, reloads, blank and absent EEPROM.
// Assumes the EEPROM model on an open-drain bus with pull-ups.
module scel_loader_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        linkClock;
  logic        rst;
  logic        sdaOe;
  logic        sclOe;
  logic        eepLow;
  logic        present;
  logic        regWrite;
  logic        regRead;
  logic        pciRetry;
  logic        loadDone;
  logic        cabIn;
  logic        cabOut;
  logic [7:0]  regAddr;
  logic [31:0] regWriteData;
  logic [31:0] regReadData;
  logic [31:0] rd;
  logic [7:0]  img [0:22];
  int          badCount = 0;
  int          totalChecks = 0;
  int          cycles = 0;
  wire         sdaWire = !(sdaOe || eepLow);
  wire         sclWire = !sclOe;

  scel_loader uut (
    .clock(clock), .rst(rst), .clockEnable(1'b1), .linkClock(linkClock),
    .sdaIn(sdaWire), .sdaOut(), .sdaOe(sdaOe), .sclOut(), .sclOe(sclOe),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
    .regRead(regRead), .regReadData(regReadData), .pciRetry(pciRetry),
    .loadDone(loadDone), .cableInactiveStatus(cabIn), .cableInactiveOutput(cabOut)
  );
  scel_eeprom_model eeprom (.scl(sclWire), .sda(sdaWire), .present(present), .sdaLow(eepLow));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    linkClock = 1'b0;
    #37;
    forever #80 linkClock = ~linkClock;
  end
  // Four loads take about 46000 cycles, the last one stopping early on the missing acknowledge.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      badCount = badCount + 1;
      endOfTest();
    end
  end

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regReadData;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] v;
    regRd(a, v);
    check(name, exp, v);
  endtask
  task automatic setImage(input logic blank, input logic cab);
    for (int i = 0; i < 23; i++) begin
      img[i] = blank ? 8'hFF : {i[4:0], 3'h0};
      if (i == 22 && !blank) img[i] = {cab, 7'h08};
      eeprom.mem[i] = img[i];
    end
  endtask
  task automatic waitDone();
    int n;
    n = 0;
    while (loadDone !== 1'b1 && n < 30000) begin
      @(posedge clock);
      n++;
    end
    repeat (2) @(posedge clock);
    #1 check("loadDone", 32'h1, {31'h0, loadDone});
    check("retryOff", 32'h0, {31'h0, pciRetry});
  endtask
  task automatic reload();
    regWr(scel_pkg::REG_CONTROL, 32'h1);
    repeat (3) @(posedge clock);
    #1 check("reloadBusy", 32'h1, {31'h0, pciRetry});
    waitDone();
  endtask
  task automatic checkRegs(input logic noack);
    rdChk(scel_pkg::REG_IDS, {img[4], img[3], img[2], img[1]}, "ids");
    rdChk(scel_pkg::REG_GUID_HI, {img[10], img[9], img[8], img[7]}, "guidHi");
    rdChk(scel_pkg::REG_GUID_LO, {img[14], img[13], img[12], img[11]}, "guidLo");
    rdChk(scel_pkg::REG_CFG_A, {img[22], img[20], img[6], img[5]}, "cfgA");
    rdChk(scel_pkg::REG_CFG_B, {img[18], img[17], img[16], img[0]}, "cfgB");
    regRd(scel_pkg::REG_STATUS, rd);
    check("status", {28'h0, img[22][7], noack, 2'h2}, rd & 32'h0000_000F);
  endtask
  task automatic cabCheck(input logic en);
    @(posedge clock);
    cabIn <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check("cabOn", {31'h0, en}, {31'h0, cabOut});
    @(posedge clock);
    cabIn <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check("cabOff", 32'h0, {31'h0, cabOut});
  endtask

  initial begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWriteData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    cabIn = 1'b0;
    present = 1'b1;
    setImage(1'b0, 1'b1);
    // Reset spans two link clock edges as well.
    repeat (40) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 check("retryLoad", 32'h1, {31'h0, pciRetry});
    regRd(scel_pkg::REG_STATUS, rd);
    check("busy", 32'h1, {31'h0, rd[0]});
    // A reload while busy is ignored, so the byte count below still reaches its end.
    regWr(scel_pkg::REG_CONTROL, 32'h1);
    waitDone();
    checkRegs(1'b0);
    regRd(scel_pkg::REG_STATUS, rd);
    check("count", {27'h0, scel_pkg::LOAD_COUNT}, {27'h0, rd[12:8]});
    rdChk(8'hFC, 32'h0, "unmapped");
    regWr(scel_pkg::REG_IDS, 32'h1234_5678);
    rdChk(scel_pkg::REG_IDS, {img[4], img[3], img[2], img[1]}, "idsRo");
    cabCheck(1'b1);
    setImage(1'b0, 1'b0);
    reload();
    checkRegs(1'b0);
    cabCheck(1'b0);
    setImage(1'b1, 1'b0);
    reload();
    checkRegs(1'b0);
    cabCheck(1'b1);
    @(posedge clock);
    present <= 1'b0;
    reload();
    checkRegs(1'b1);
    endOfTest();
  end
endmodule
